// ---- src/rdfp_defines.vh ----
// Shared constants for the radio data FIFO pair: offsets, fields and reset values.
`ifndef RDFP_DEFINES_VH
`define RDFP_DEFINES_VH

// ----------------------------------------------------------------------------
// FIFO geometry
// ----------------------------------------------------------------------------
`define RDFP_DATA_W 8
`define RDFP_DEPTH 64
`define RDFP_PTR_W 6
`define RDFP_CNT_W 7

// ----------------------------------------------------------------------------
// APB register byte offsets
// ----------------------------------------------------------------------------
`define RDFP_OFS_THR_CFG 8'h00
`define RDFP_OFS_RX_COUNT 8'h04
`define RDFP_OFS_TX_COUNT 8'h08
`define RDFP_OFS_INT_STATUS 8'h0C
`define RDFP_OFS_INT_MASK 8'h10
`define RDFP_OFS_GPO_CFG 8'h14
`define RDFP_OFS_FLUSH 8'h18

// ----------------------------------------------------------------------------
// Register fields and reset values
// ----------------------------------------------------------------------------
`define RDFP_THR_W 4
`define RDFP_THR_RESET 4'h7
`define RDFP_MASK_RESET 5'h00
`define RDFP_GPO_RESET 4'h4
`define RDFP_INT_W 5
`define RDFP_INT_RX_OVF 0
`define RDFP_INT_TX_UNF 1
`define RDFP_INT_RX_THR 2
`define RDFP_INT_TX_THR 3
`define RDFP_INT_TX_OVF 4
`define RDFP_ERR_BIT 7
`define RDFP_FLUSH_RX 0
`define RDFP_FLUSH_TX 1

// ----------------------------------------------------------------------------
// Threshold encodings
// ----------------------------------------------------------------------------
`define RDFP_RX_THR_STEP 7'h04
`define RDFP_TX_THR_BASE 7'h3D

// ----------------------------------------------------------------------------
// Output pin selections
// ----------------------------------------------------------------------------
`define RDFP_GPO_RX_THR 2'h0
`define RDFP_GPO_TX_THR 2'h1
`define RDFP_GPO_LOW 2'h2
`define RDFP_GPO_HIGH 2'h3

// ----------------------------------------------------------------------------
// Serial access
// ----------------------------------------------------------------------------
`define RDFP_SPI_FIFO_ADDR 6'h3F
`define RDFP_STATUS_TOP 4'h0

`endif

// ---- src/rdfp_fifo.v ----
// One 64 x 8 byte FIFO with pointer-derived fill count and error pulses.
`timescale 1ns/1ps
`default_nettype none

`include "rdfp_defines.vh"

module rdfp_fifo (
   // Clock and reset.
   input wire pclk,
   input wire presetn,
   // Control.
   input wire flush,
   input wire dup_quirk,
   // Fill side.
   input wire push,
   input wire [`RDFP_DATA_W-1:0] push_data,
   // Drain side.
   input wire pop,
   output wire [`RDFP_DATA_W-1:0] head_data,
   // State.
   output wire [`RDFP_CNT_W-1:0] count,
   output wire full,
   output wire empty,
   output wire overflow,
   output wire underflow
);

   reg [`RDFP_DATA_W-1:0] mem [0:`RDFP_DEPTH-1];
   reg [`RDFP_CNT_W-1:0] wr_ptr;
   reg [`RDFP_CNT_W-1:0] rd_ptr;
   wire do_push;
   wire do_pop;
   wire stuck;

   assign count = wr_ptr - rd_ptr;
   assign full = (count == `RDFP_DEPTH);
   assign empty = (count == {`RDFP_CNT_W{1'b0}});
   assign do_push = push & ~full;
   assign do_pop = pop & ~empty;
   assign overflow = push & full;
   assign underflow = pop & empty;
   assign head_data = mem[rd_ptr[`RDFP_PTR_W-1:0]];
   // A write meeting the read of the last byte leaves the read pointer behind.
   assign stuck = dup_quirk & do_push & do_pop & (count == 7'h01); // [RQ8]

   always @(posedge pclk) begin
      if (do_push) begin
         mem[wr_ptr[`RDFP_PTR_W-1:0]] <= push_data;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr <= 7'h00;
         rd_ptr <= 7'h00;
      end else if (flush) begin
         wr_ptr <= 7'h00;
         rd_ptr <= 7'h00;
      end else begin
         if (do_push) begin
            wr_ptr <= wr_ptr + 7'h01;
         end
         if (do_pop && !stuck) begin
            rd_ptr <= rd_ptr + 7'h01;
         end
      end
   end

endmodule // rdfp_fifo

`default_nettype wire

// ---- src/rdfp_top.v ----
// Radio data FIFO pair: serial host access, radio side ports, APB status and control.
//
// What this block does
// [RQ1] Two separate 64-byte FIFOs, receive and transmit.
// [RQ2] Serial writes fill transmit, serial reads drain receive.
// [RQ3] Flag receive overflow and transmit underflow.
// [RQ4] Host never overfills the transmit FIFO.
// [RQ5] Host never reads an empty receive FIFO.
// [RQ6] Header status byte carries fill of accessed FIFO.
// [RQ7] Readable byte counts for both FIFOs.
// [RQ8] Write during last-byte read duplicates that byte.
// [RQ9] Host keeps receive FIFO nonempty until packet end.
// [RQ10] Short packets: read once fully received.
// [RQ11] Long packets: poll count twice, read n-1.
// [RQ12] Four-bit field selects sixteen shared thresholds.
// [RQ13] Receive 4(v+1), transmit 61-4v bytes.
// [RQ14] Threshold asserts at count >= level, drives pins.
// [RQ15] Sleep entry empties both FIFOs.
// [RQ16] Threshold deasserts below level.
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

`include "rdfp_defines.vh"

module rdfp_top (
   // Clock and reset.
   input wire pclk,
   input wire presetn,
   // APB slave.
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // Serial host pins.
   input wire spi_csn,
   input wire spi_sclk,
   input wire spi_mosi,
   output reg spi_miso,
   output wire spi_miso_oe,
   // Radio side, same clock.
   input wire rx_byte_valid,
   input wire [7:0] rx_byte,
   input wire tx_byte_req,
   output wire [7:0] tx_byte,
   output wire tx_empty,
   input wire sleep_enter,
   // Outputs.
   output reg [1:0] general_output_pin,
   output wire irq
);

   // -------------------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------------------
   reg [2:0] sync_a;
   reg [2:0] sync_b;
   reg sclk_d;
   reg csn_d;
   wire csn_s;
   wire sclk_s;
   wire mosi_s;
   wire sclk_rise;
   wire sclk_fall;
   wire csn_fall;

   assign csn_s = sync_b[0];
   assign sclk_s = sync_b[1];
   assign mosi_s = sync_b[2];
   assign sclk_rise = sclk_s & ~sclk_d & ~csn_s;
   assign sclk_fall = ~sclk_s & sclk_d & ~csn_s;
   assign csn_fall = ~csn_s & csn_d;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_a <= 3'h1;
         sync_b <= 3'h1;
         sclk_d <= 1'b0;
         csn_d <= 1'b1;
      end else begin
         sync_a <= {spi_mosi, spi_sclk, spi_csn};
         sync_b <= sync_a;
         sclk_d <= sclk_s;
         csn_d <= csn_s;
      end
   end

   // -------------------------------------------------------------------------
   // FIFOs
   // -------------------------------------------------------------------------
   wire rx_pop;
   wire tx_push;
   wire [7:0] rx_head;
   wire [6:0] rx_count;
   wire [6:0] tx_count;
   wire rx_empty;
   wire rx_ovf;
   wire tx_unf;
   wire tx_ovf;
   reg [7:0] shift_in;
   reg flush_rx;
   reg flush_tx;

   // [RQ1]
   rdfp_fifo u_rx_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .flush(flush_rx),
      .dup_quirk(1'b1),
      .push(rx_byte_valid),
      .push_data(rx_byte),
      .pop(rx_pop),
      .head_data(rx_head),
      .count(rx_count),
      .full(),
      .empty(rx_empty),
      .overflow(rx_ovf),
      .underflow()
   );

   rdfp_fifo u_tx_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .flush(flush_tx),
      .dup_quirk(1'b0),
      .push(tx_push),
      .push_data({shift_in[6:0], mosi_s}),
      .pop(tx_byte_req),
      .head_data(tx_byte),
      .count(tx_count),
      .full(),
      .empty(tx_empty),
      .overflow(tx_ovf),
      .underflow(tx_unf)
   );

   // -------------------------------------------------------------------------
   // Serial access engine
   // -------------------------------------------------------------------------
   reg [2:0] bit_cnt;
   reg in_header;
   reg is_read;
   reg fifo_sel;
   reg boundary;
   reg [7:0] out_byte;
   wire byte_done;
   wire [7:0] byte_now;
   wire [3:0] rx_nib;
   wire [3:0] tx_nib;

   assign byte_done = sclk_rise & (bit_cnt == 3'h7);
   assign byte_now = {shift_in[6:0], mosi_s};
   assign spi_miso_oe = ~csn_s;
   // The status nibble saturates since only four bits are available for a 0..64 count.
   assign rx_nib = (rx_count > 7'h0F) ? 4'hF : rx_count[3:0];
   assign tx_nib = (tx_count > 7'h0F) ? 4'hF : tx_count[3:0];
   // Data bytes only move for the FIFO address; other addresses live behind APB.
   assign tx_push = byte_done & ~in_header & ~is_read & fifo_sel; // [RQ2]
   assign rx_pop = byte_done & ~in_header & is_read & fifo_sel; // [RQ2]

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_cnt <= 3'h0;
         in_header <= 1'b1;
         is_read <= 1'b0;
         fifo_sel <= 1'b0;
         boundary <= 1'b0;
         shift_in <= 8'h00;
         out_byte <= 8'h00;
         spi_miso <= 1'b0;
      end else if (csn_s) begin
         bit_cnt <= 3'h0;
         in_header <= 1'b1;
         boundary <= 1'b0;
      end else begin
         if (csn_fall) begin
            spi_miso <= 1'b0;
         end
         if (sclk_rise) begin
            bit_cnt <= bit_cnt + 3'h1;
            shift_in <= byte_now;
            if (in_header && bit_cnt == 3'h0) begin
               // The direction bit is first in, so the fill nibble can follow it.
               out_byte <= {`RDFP_STATUS_TOP, mosi_s ? rx_nib : tx_nib}; // [RQ6]
            end
         end
         if (byte_done) begin
            boundary <= 1'b1;
            if (in_header) begin
               in_header <= 1'b0;
               is_read <= byte_now[7];
               fifo_sel <= (byte_now[5:0] == `RDFP_SPI_FIFO_ADDR);
            end
         end
         if (sclk_fall) begin
            if (boundary) begin
               // Peek at the head here; the pop waits until the byte is fully out.
               boundary <= 1'b0;
               out_byte <= (is_read && fifo_sel) ? rx_head : 8'h00;
               spi_miso <= (is_read && fifo_sel) ? rx_head[7] : 1'b0;
            end else begin
               spi_miso <= out_byte[3'h7 - bit_cnt];
            end
         end
      end
   end

   // -------------------------------------------------------------------------
   // Thresholds and output pins
   // -------------------------------------------------------------------------
   reg [3:0] fifo_threshold_select;
   reg [3:0] gpo_cfg;
   reg rx_thr_hit;
   reg tx_thr_hit;
   wire [6:0] rx_level;
   wire [6:0] tx_level;
   wire next_rx_thr;
   wire next_tx_thr;

   assign rx_level = {1'b0, fifo_threshold_select, 2'b00} + `RDFP_RX_THR_STEP; // [RQ13]
   assign tx_level = `RDFP_TX_THR_BASE - {1'b0, fifo_threshold_select, 2'b00}; // [RQ13]
   assign next_rx_thr = (rx_count >= rx_level); // [RQ14] [RQ16]
   assign next_tx_thr = (tx_count >= tx_level); // [RQ14] [RQ16]

   function sel_pin;
      input [1:0] cfg;
      input rx_hit;
      input tx_hit;
      begin
         case (cfg)
            `RDFP_GPO_RX_THR: sel_pin = rx_hit;
            `RDFP_GPO_TX_THR: sel_pin = tx_hit;
            `RDFP_GPO_HIGH: sel_pin = 1'b1;
            default: sel_pin = 1'b0;
         endcase
      end
   endfunction

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_thr_hit <= 1'b0;
         tx_thr_hit <= 1'b0;
         general_output_pin <= 2'h0;
      end else begin
         rx_thr_hit <= next_rx_thr;
         tx_thr_hit <= next_tx_thr;
         general_output_pin[0] <= sel_pin(gpo_cfg[1:0], next_rx_thr, next_tx_thr); // [RQ14]
         general_output_pin[1] <= sel_pin(gpo_cfg[3:2], next_rx_thr, next_tx_thr); // [RQ14]
      end
   end

   // -------------------------------------------------------------------------
   // Error flags, flush and interrupts
   // -------------------------------------------------------------------------
   reg rx_err;
   reg tx_err;
   reg [4:0] int_status;
   reg [4:0] int_mask;
   wire [4:0] int_event;
   wire apb_wr;
   wire apb_rd_done;
   wire flush_wr;

   assign apb_wr = psel & penable & pwrite;
   assign apb_rd_done = psel & penable & ~pwrite;
   assign flush_wr = apb_wr & (paddr == `RDFP_OFS_FLUSH);
   assign int_event = {tx_ovf, next_tx_thr & ~tx_thr_hit, next_rx_thr & ~rx_thr_hit,
      tx_unf, rx_ovf}; // [RQ3]
   assign irq = |(int_status & int_mask);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flush_rx <= 1'b0;
         flush_tx <= 1'b0;
      end else begin
         // Sleep drops both FIFOs, as the memory is unpowered there.
         flush_rx <= sleep_enter | (flush_wr & pwdata[`RDFP_FLUSH_RX]); // [RQ15]
         flush_tx <= sleep_enter | (flush_wr & pwdata[`RDFP_FLUSH_TX]); // [RQ15]
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_err <= 1'b0;
         tx_err <= 1'b0;
      end else begin
         // The error bits stick until the FIFO is flushed, since its content is suspect.
         if (rx_ovf) begin
            rx_err <= 1'b1; // [RQ3]
         end else if (flush_rx) begin
            rx_err <= 1'b0;
         end
         if (tx_unf) begin
            tx_err <= 1'b1; // [RQ3]
         end else if (flush_tx) begin
            tx_err <= 1'b0;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_status <= 5'h00;
      end else if (apb_rd_done && paddr == `RDFP_OFS_INT_STATUS) begin
         int_status <= int_event;
      end else begin
         int_status <= int_status | int_event;
      end
   end

   // -------------------------------------------------------------------------
   // APB registers
   // -------------------------------------------------------------------------
   reg mapped;

   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   always @* begin
      case (paddr)
         `RDFP_OFS_THR_CFG,
         `RDFP_OFS_RX_COUNT,
         `RDFP_OFS_TX_COUNT,
         `RDFP_OFS_INT_STATUS,
         `RDFP_OFS_INT_MASK,
         `RDFP_OFS_GPO_CFG,
         `RDFP_OFS_FLUSH: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fifo_threshold_select <= `RDFP_THR_RESET;
         int_mask <= `RDFP_MASK_RESET;
         gpo_cfg <= `RDFP_GPO_RESET;
      end else if (apb_wr) begin
         case (paddr)
            `RDFP_OFS_THR_CFG: fifo_threshold_select <= pwdata[3:0]; // [RQ12]
            `RDFP_OFS_INT_MASK: int_mask <= pwdata[4:0];
            `RDFP_OFS_GPO_CFG: gpo_cfg <= pwdata[3:0];
            default: gpo_cfg <= gpo_cfg;
         endcase
      end
   end

   // Read data is captured in the setup cycle so the one-cycle access can return it.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            `RDFP_OFS_THR_CFG: prdata <= {28'h0000000, fifo_threshold_select};
            `RDFP_OFS_RX_COUNT: prdata <= {24'h000000, rx_err, rx_count}; // [RQ7]
            `RDFP_OFS_TX_COUNT: prdata <= {24'h000000, tx_err, tx_count}; // [RQ7]
            `RDFP_OFS_INT_STATUS: prdata <= {27'h0000000, int_status | int_event};
            `RDFP_OFS_INT_MASK: prdata <= {27'h0000000, int_mask};
            `RDFP_OFS_GPO_CFG: prdata <= {28'h0000000, gpo_cfg};
            default: prdata <= 32'h00000000;
         endcase
      end
   end

endmodule // rdfp_top

`default_nettype wire

// ---- dv/rdfp_properties.sv ----
// Port-level concurrent checks for the radio data FIFO pair.
`timescale 1ns/1ps
`default_nettype none
module rdfp_properties (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Serial pins.
   input wire logic spi_csn,
   input wire logic spi_sclk,
   input wire logic spi_mosi,
   input wire logic spi_miso,
   input wire logic spi_miso_oe,
   // Radio side.
   input wire logic rx_byte_valid,
   input wire logic [7:0] rx_byte,
   input wire logic tx_byte_req,
   input wire logic [7:0] tx_byte,
   input wire logic tx_empty,
   input wire logic sleep_enter,
   // Outputs.
   input wire logic [1:0] general_output_pin,
   input wire logic irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic acc = psel && penable;
   wire logic mapped = (paddr[1:0] == 2'h0) && (paddr <= 8'h18);

   a_ready_always: assert property (pready)
      else $error("pready low");
   a_err_unmapped: assert property (acc && !mapped |-> pslverr)
      else $error("no error on unmapped access");
   a_err_access_only: assert property (pslverr |-> acc && !mapped)
      else $error("stray pslverr");
   a_rd_unmapped_zero: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_oe_on_select: assert property ((!spi_csn) [*4] |-> spi_miso_oe)
      else $error("serial output not driven while selected");
   a_oe_off_idle: assert property (spi_csn [*4] |-> !spi_miso_oe)
      else $error("serial output driven while idle");
   a_sleep_empties: assert property (sleep_enter |-> ##[1:3] tx_empty)
      else $error("transmit side not emptied by sleep");
   a_mask_clear_irq: assert property (acc && pwrite && paddr == 8'h10 && pwdata[4:0] == 5'h00
      |=> !irq)
      else $error("irq high with all sources masked");
   a_head_holds: assert property (!tx_empty && !tx_byte_req && !sleep_enter ##1 !tx_empty
      |-> $stable(tx_byte))
      else $error("transmit head changed without a pop");
   a_clean_start: assert property ($rose(presetn) |-> tx_empty && !irq
      && general_output_pin == 2'h0)
      else $error("state after reset not clean");

   c_unmapped: cover property (pslverr);
   c_irq: cover property ($rose(irq));
   c_sleep: cover property (sleep_enter ##2 tx_empty);
   c_tx_fill: cover property ($fell(tx_empty));
endmodule // rdfp_properties

bind rdfp_top rdfp_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .spi_csn(spi_csn), .spi_sclk(spi_sclk),
   .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
   .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .tx_byte_req(tx_byte_req),
   .tx_byte(tx_byte), .tx_empty(tx_empty), .sleep_enter(sleep_enter),
   .general_output_pin(general_output_pin), .irq(irq));
`default_nettype wire

// ---- dv/rdfp_spi_host.sv ----
// Serial host model that frames transfers to and from the FIFO pair.
`timescale 1ns/1ps
`default_nettype none
module rdfp_spi_host (
   // Serial pins.
   output logic spi_csn,
   output logic spi_sclk,
   output logic spi_mosi,
   input wire logic miso_line
);
   localparam realtime HALF = 62.5;
   logic [7:0] wdat [0:63];
   logic [7:0] rdat [0:63];
   logic [7:0] status;
   initial begin
      spi_csn = 1'b1;
      spi_sclk = 1'b0;
      spi_mosi = 1'b0;
   end
   // Mode 0, MSB first; the clock stands low outside frames.
   task automatic shift(input logic [7:0] o, output logic [7:0] i);
      for (int b = 7; b >= 0; b--) begin
         spi_mosi = o[b];
         #HALF;
         i[b] = miso_line;
         spi_sclk = 1'b1;
         #HALF;
         spi_sclk = 1'b0;
      end
   endtask
   // The odd start offset keeps every serial edge off the block clock's edges.
   task automatic frame(input logic [7:0] hdr, input int n);
      logic [7:0] d;
      #1.3;
      spi_csn = 1'b0;
      #HALF;
      shift(hdr, status);
      for (int k = 0; k < n; k++) begin
         shift(wdat[k], d);
         rdat[k] = d;
      end
      #HALF;
      spi_csn = 1'b1;
      #HALF;
   endtask
endmodule // rdfp_spi_host
`default_nettype wire

// ---- dv/radio_data_fifo_pair_tb_top.sv ----
// Self-checking bench for the radio data FIFO pair.
`timescale 1ns/1ps
`default_nettype none
`include "rdfp_defines.vh"
module radio_data_fifo_pair_tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err_seen;
   logic [7:0] paddr = 8'h00, rx_byte = 8'h00, tx_byte;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, irq, tx_empty, idle_pat = 1'b0;
   logic spi_csn, spi_sclk, spi_mosi, spi_miso, spi_miso_oe, miso_line;
   logic rx_byte_valid = 1'b0, tx_byte_req = 1'b0, sleep_enter = 1'b0;
   logic [1:0] general_output_pin;
   int err_count = 0, checks_done = 0, cycles = 0;
   always #2.5 pclk = ~pclk;
   // A released serial line shows a changing pattern so a held level cannot pass.
   always @(posedge pclk) idle_pat <= ~idle_pat;
   assign miso_line = spi_miso_oe ? spi_miso : idle_pat;
   rdfp_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .spi_csn(spi_csn), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
      .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .rx_byte_valid(rx_byte_valid),
      .rx_byte(rx_byte), .tx_byte_req(tx_byte_req), .tx_byte(tx_byte), .tx_empty(tx_empty),
      .sleep_enter(sleep_enter), .general_output_pin(general_output_pin), .irq(irq));
   rdfp_spi_host u_host (.spi_csn(spi_csn), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
      .miso_line(miso_line));
   // --------------------------------------------------------------
   // Shared tasks
   // --------------------------------------------------------------
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         err_count = err_count + 1;
         summarize();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask
   task automatic spi(input logic [7:0] hdr, input int n);
      u_host.frame(hdr, n);
      @(posedge pclk);
   endtask
   task automatic pulse_pop();
      tx_byte_req <= 1'b1;
      @(posedge pclk);
      tx_byte_req <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rx_push(input int n, input logic [7:0] base);
      for (int k = 0; k < n; k++) begin
         rx_byte_valid <= 1'b1;
         rx_byte <= base + k[7:0];
         @(posedge pclk);
      end
      rx_byte_valid <= 1'b0;
      @(posedge pclk);
   endtask
   // --------------------------------------------------------------
   // Scenarios
   // --------------------------------------------------------------
   task automatic t_reset();
      rchk(`RDFP_OFS_THR_CFG, {28'h0, `RDFP_THR_RESET});
      rchk(`RDFP_OFS_TX_COUNT, 32'h0);
      rchk(`RDFP_OFS_INT_MASK, 32'h0);
      rchk(`RDFP_OFS_GPO_CFG, {28'h0, `RDFP_GPO_RESET});
      apb(1'b1, `RDFP_OFS_RX_COUNT, 32'h55);
      rchk(`RDFP_OFS_RX_COUNT, 32'h0);
      apb(1'b1, 8'h1C, 32'hF);
      check(err_seen, 1'b1);
      rchk(8'h1C, 32'h0);
      check(general_output_pin, 2'h0);
   endtask
   task automatic t_tx();
      for (int k = 0; k < 3; k++) u_host.wdat[k] = 8'hA0 + k[7:0];
      spi(8'h3F, 3);
      check(u_host.status, 8'h00);
      u_host.wdat[0] = 8'h5C;
      spi(8'h3F, 1);
      check(u_host.status, 8'h03);
      rchk(`RDFP_OFS_TX_COUNT, 32'h4);
      for (int k = 0; k < 4; k++) begin
         check(tx_byte, k < 3 ? 8'hA0 + k[7:0] : 8'h5C);
         pulse_pop();
      end
      check(tx_empty, 1'b1);
      pulse_pop();
      check(irq, 1'b0);
      apb(1'b1, `RDFP_OFS_INT_MASK, 32'h2);
      check(irq, 1'b1);
      rchk(`RDFP_OFS_TX_COUNT, 32'h80);
      rchk(`RDFP_OFS_INT_STATUS, 32'h2);
      check(irq, 1'b0);
      apb(1'b1, `RDFP_OFS_INT_MASK, 32'h0);
   endtask
   task automatic t_rx();
      rx_push(20, 8'h10);
      apb(1'b0, `RDFP_OFS_RX_COUNT, 32'h0);
      rchk(`RDFP_OFS_RX_COUNT, rd);
      check(rd, 32'h14);
      spi(8'hBF, 4);
      check(u_host.status, 8'h0F);
      for (int k = 0; k < 4; k++) check(u_host.rdat[k], 8'h10 + k[7:0]);
      rchk(`RDFP_OFS_RX_COUNT, 32'h10);
   endtask
   task automatic t_thr();
      rx_push(16, 8'h40);
      for (int k = 0; k < 33; k++) u_host.wdat[k] = k[7:0];
      spi(8'h3F, 33);
      for (int v = 0; v < 16; v++) begin
         apb(1'b1, `RDFP_OFS_THR_CFG, v);
         idle(1);
         check(general_output_pin, {30'h0, 61 - 4 * v <= 33, 4 * v + 4 <= 32});
      end
      apb(1'b1, `RDFP_OFS_THR_CFG, 32'h7);
      spi(8'hBF, 1);
      idle(1);
      check(general_output_pin, 2'h2);
      rx_push(1, 8'h50);
      idle(1);
      check(general_output_pin, 2'h3);
      apb(1'b1, `RDFP_OFS_GPO_CFG, 32'hE);
      idle(1);
      check(general_output_pin, 2'h2);
      apb(1'b1, `RDFP_OFS_GPO_CFG, 32'h4);
   endtask
   task automatic t_ovf_sleep();
      rx_push(33, 8'h60);
      rchk(`RDFP_OFS_RX_COUNT, 32'hC0);
      apb(1'b0, `RDFP_OFS_INT_STATUS, 32'h0);
      check(rd, 32'hD);
      sleep_enter <= 1'b1;
      @(posedge pclk);
      sleep_enter <= 1'b0;
      idle(3);
      check(tx_empty, 1'b1);
      rchk(`RDFP_OFS_RX_COUNT, 32'h0);
      apb(1'b0, `RDFP_OFS_TX_COUNT, 32'h0);
      check(rd[6:0], 7'h0);
      rx_push(2, 8'h70);
      apb(1'b1, `RDFP_OFS_FLUSH, 32'h1);
      idle(1);
      rchk(`RDFP_OFS_RX_COUNT, 32'h0);
      // A radio byte lands in the very cycle that pops the last stored byte.
      rx_push(1, 8'h81);
      fork
         spi(8'hBF, 2);
         begin
            repeat (16) @(posedge spi_sclk);
            repeat (2) @(posedge pclk);
            rx_byte_valid <= 1'b1;
            rx_byte <= 8'h82;
            @(posedge pclk);
            rx_byte_valid <= 1'b0;
         end
      join
      check(u_host.rdat[0], 8'h81);
      check(u_host.rdat[1], 8'h81);
      rchk(`RDFP_OFS_RX_COUNT, 32'h1);
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      idle(3);
      t_reset();
      t_tx();
      t_rx();
      t_thr();
      t_ovf_sleep();
      summarize();
   end
endmodule // radio_data_fifo_pair_tb_top
`default_nettype wire
